// >>> tbd_detector.sv
// trace bucket detector: reduces envelope samples to one value per point
// Functional notes
// - bucket width is span over points minus one
// - bucket time is sweep over points minus one
// - trace points configurable from 1 to 40001
// - sample mode keeps the bucket midpoint sample
// - positive peak outputs bucket maximum
// - negative peak outputs bucket minimum
// - normal mode: rose and fell means noise
// - noise even bucket: output min, store max
// - noise odd bucket: max of own, stored max
// - one-direction bucket outputs its maximum
// - positive peak is the reset default mode
//
// Implementation choices: the Wishbone interface to the registers and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module tbd_detector #(
    parameter int SAMPLE_W = tbd_pkg::SAMPLE_W,
    parameter int POINTS_W = tbd_pkg::POINTS_W
) (
    input  wire logic                clk,
    input  wire logic                rst,
    input  wire logic [31:0]         wb_adr_i,
    input  wire logic [31:0]         wb_dat_i,
    output logic      [31:0]         wb_dat_o,
    input  wire logic                wb_we_i,
    input  wire logic [3:0]          wb_sel_i,
    input  wire logic                wb_stb_i,
    input  wire logic                wb_cyc_i,
    output logic                     wb_ack_o,
    output logic                     wb_err_o,
    input  wire logic                smp_valid,
    input  wire logic [SAMPLE_W-1:0] smp_data,
    output logic                     pt_valid,
    output logic      [POINTS_W-1:0] pt_index,
    output logic      [SAMPLE_W-1:0] pt_value,
    output logic                     sweep_done
);
    localparam int CW = tbd_pkg::COUNT_W;

    // refused at elaboration: the register map is laid out for these widths
    if (SAMPLE_W != tbd_pkg::SAMPLE_W ||
        POINTS_W != tbd_pkg::POINTS_W) begin : g_width_chk
        $error("tbd_detector: widths must match package");
    end

    // unsigned compare helpers, used by several trackers
    function automatic logic [SAMPLE_W-1:0] max_of(
        input logic [SAMPLE_W-1:0] a, input logic [SAMPLE_W-1:0] b);
        max_of = (a > b) ? a : b;
    endfunction
    function automatic logic [SAMPLE_W-1:0] min_of(
        input logic [SAMPLE_W-1:0] a, input logic [SAMPLE_W-1:0] b);
        min_of = (a < b) ? a : b;
    endfunction
    function automatic logic [31:0] merge(
        input logic [31:0] old, input logic [31:0] nw, input logic [3:0] sel);
        for (int i = 0; i < 4; i++)
            merge[8*i +: 8] = sel[i] ? nw[8*i +: 8] : old[8*i +: 8];
    endfunction

    // configuration registers
    tbd_pkg::tbd_mode_e  mode_q;
    logic [POINTS_W-1:0] points_q;
    logic [CW-1:0]       span_q;
    logic [CW-1:0]       sweep_q;
    logic [CW-1:0]       bwidth_q;
    logic [CW-1:0]       btime_q;
    tbd_pkg::tbd_point_s last_q;
    tbd_pkg::tbd_state_e state_q;
    logic                div_sel_q;

    // bus decode
    logic        bus_req;
    logic        wr_en;
    logic [7:0]  adr;
    logic        mapped;
    logic        start_req;
    logic [31:0] wdat;
    logic [31:0] pts_wr;

    assign bus_req = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
    assign adr     = wb_adr_i[7:0];
    assign mapped  = (wb_adr_i[31:8] == 24'h0) && (adr[1:0] == 2'b00)
                     && (adr <= tbd_pkg::ADDR_LAST);
    assign wr_en   = bus_req && wb_we_i && mapped;

    // single-cycle ack; unmapped addresses answer with err
    always_ff @(posedge clk) begin
        if (rst) begin
            wb_ack_o <= 1'b0;
            wb_err_o <= 1'b0;
        end else begin
            wb_ack_o <= bus_req && mapped;
            wb_err_o <= bus_req && !mapped;
        end
    end

    // read mux, registered so the data stands with ack
    always_ff @(posedge clk) begin
        if (rst) begin
            wb_dat_o <= 32'h0000_0000;
        end else if (bus_req) begin
            case (adr)
                tbd_pkg::ADDR_CTRL:   wb_dat_o <= {30'h0, mode_q};
                tbd_pkg::ADDR_POINTS: wb_dat_o <= {16'h0, points_q};
                tbd_pkg::ADDR_SPAN:   wb_dat_o <= span_q;
                tbd_pkg::ADDR_SWEEP:  wb_dat_o <= sweep_q;
                tbd_pkg::ADDR_BWIDTH: wb_dat_o <= bwidth_q;
                tbd_pkg::ADDR_BTIME:  wb_dat_o <= btime_q;
                tbd_pkg::ADDR_STATUS: wb_dat_o <= {30'h0,
                    state_q == tbd_pkg::TBD_ST_DIV,
                    state_q != tbd_pkg::TBD_ST_IDLE};
                tbd_pkg::ADDR_LAST:   wb_dat_o <= {last_q.index,
                                                   last_q.value};
                default:              wb_dat_o <= 32'h0000_0000;
            endcase
        end
    end

    assign wdat      = merge(32'h0, wb_dat_i, wb_sel_i);
    assign pts_wr    = merge({16'h0, points_q}, wb_dat_i, wb_sel_i);
    assign start_req = wr_en && (adr == tbd_pkg::ADDR_CTRL)
                       && wb_sel_i[0] && wdat[tbd_pkg::CTRL_START];

    // writable configuration; span and sweep changes take effect at the next sweep start, mode and points at once
    always_ff @(posedge clk) begin
        if (rst) begin
            mode_q   <= tbd_pkg::MODE_RST;
            points_q <= tbd_pkg::POINTS_RST;
            span_q   <= tbd_pkg::SPAN_RST;
            sweep_q  <= tbd_pkg::SWEEP_RST;
        end else if (wr_en) begin
            case (adr)
                tbd_pkg::ADDR_CTRL:
                    if (wb_sel_i[0])
                        mode_q <= tbd_pkg::tbd_mode_e'(
                            wdat[tbd_pkg::CTRL_MODE_LSB +: 2]);
                tbd_pkg::ADDR_POINTS: begin
                    // clamp to the legal range of points
                    if (pts_wr > 32'(tbd_pkg::MAX_POINTS))
                        points_q <= POINTS_W'(tbd_pkg::MAX_POINTS);
                    else if (pts_wr == 32'h0)
                        points_q <= tbd_pkg::MIN_POINTS;
                    else
                        points_q <= pts_wr[POINTS_W-1:0];
                end
                tbd_pkg::ADDR_SPAN:
                    span_q <= merge(span_q, wb_dat_i, wb_sel_i);
                tbd_pkg::ADDR_SWEEP:
                    sweep_q <= merge(sweep_q, wb_dat_i, wb_sel_i);
                default: ;
            endcase
        end
    end

    // one shared divider computes bucket width and bucket time at sweep start
    logic          div_start;
    logic          div_busy;
    logic          div_done;
    logic [CW-1:0] div_q;
    logic [CW-1:0] div_den;

    // single point has no interval; divide by one then
    assign div_den   = (points_q > tbd_pkg::MIN_POINTS)
                       ? CW'(points_q - 1'b1) : CW'(1);
    assign div_start = (state_q == tbd_pkg::TBD_ST_DIV) && !div_busy
                       && !div_done;

    tbd_div #(.W(CW)) u_div (
        .clk      (clk),
        .rst      (rst),
        .start    (div_start),
        .dividend (div_sel_q ? sweep_q : span_q),
        .divisor  (div_den),
        .busy     (div_busy),
        .done     (div_done),
        .quotient (div_q)
    );

    // sweep sequencing
    logic [CW-1:0]       tick_q;
    logic [POINTS_W-1:0] bidx_q;
    logic                bucket_end;
    logic                mid_hit;

    assign bucket_end = smp_valid && (tick_q + 1'b1 >= btime_q);
    assign mid_hit    = smp_valid && (tick_q == (btime_q >> 1));

    always_ff @(posedge clk) begin
        if (rst) begin
            state_q   <= tbd_pkg::TBD_ST_IDLE;
            div_sel_q <= 1'b0;
            bwidth_q  <= '0;
            btime_q   <= '0;
        end else begin
            case (state_q)
                tbd_pkg::TBD_ST_IDLE:
                    if (start_req) begin
                        state_q   <= tbd_pkg::TBD_ST_DIV;
                        div_sel_q <= 1'b0;
                    end
                tbd_pkg::TBD_ST_DIV:
                    if (div_done) begin
                        if (!div_sel_q) begin
                            bwidth_q  <= div_q;
                            div_sel_q <= 1'b1;
                        end else begin
                            // zero duration is raised to one sample per bucket
                            btime_q <= (div_q == '0) ? CW'(1) : div_q;
                            state_q <= tbd_pkg::TBD_ST_SWEEP;
                        end
                    end
                tbd_pkg::TBD_ST_SWEEP:
                    if (bucket_end && bidx_q >= points_q)
                        state_q <= tbd_pkg::TBD_ST_IDLE;
                default: state_q <= tbd_pkg::TBD_ST_IDLE;
            endcase
        end
    end

    // sample counter within the bucket and bucket index
    always_ff @(posedge clk) begin
        if (rst || state_q != tbd_pkg::TBD_ST_SWEEP) begin
            tick_q <= '0;
            bidx_q <= POINTS_W'(1);
        end else if (bucket_end) begin
            tick_q <= '0;
            bidx_q <= bidx_q + 1'b1;
        end else if (smp_valid) begin
            tick_q <= tick_q + 1'b1;
        end
    end

    // per-bucket trackers
    logic [SAMPLE_W-1:0] max_q;
    logic [SAMPLE_W-1:0] min_q;
    logic [SAMPLE_W-1:0] mid_q;
    logic [SAMPLE_W-1:0] prev_q;
    logic [SAMPLE_W-1:0] held_q;
    logic                first_q;
    logic                rose_q;
    logic                fell_q;
    logic [SAMPLE_W-1:0] max_n;
    logic [SAMPLE_W-1:0] min_n;
    logic [SAMPLE_W-1:0] mid_n;
    logic                rose_n;
    logic                fell_n;
    logic                sweeping;

    assign sweeping = state_q == tbd_pkg::TBD_ST_SWEEP;
    // include the current sample so the closing bucket sees it
    assign max_n  = first_q ? smp_data : max_of(max_q, smp_data);
    assign min_n  = first_q ? smp_data : min_of(min_q, smp_data);
    assign mid_n  = mid_hit ? smp_data : mid_q;
    assign rose_n = rose_q || (!first_q && smp_data > prev_q);
    assign fell_n = fell_q || (!first_q && smp_data < prev_q);

    always_ff @(posedge clk) begin
        if (rst || !sweeping) begin
            first_q <= 1'b1;
            rose_q  <= 1'b0;
            fell_q  <= 1'b0;
            max_q   <= '0;
            min_q   <= '0;
            mid_q   <= '0;
            prev_q  <= '0;
        end else if (smp_valid) begin
            prev_q  <= smp_data;
            first_q <= bucket_end;
            // flags restart at each boundary; the step across is not counted
            rose_q  <= bucket_end ? 1'b0 : rose_n;
            fell_q  <= bucket_end ? 1'b0 : fell_n;
            max_q   <= max_n;
            min_q   <= min_n;
            mid_q   <= mid_n;
        end
    end

    // remembered maximum carried between buckets in normal mode
    always_ff @(posedge clk) begin
        if (rst || !sweeping) begin
            held_q <= '0;
        end else if (bucket_end) begin
            if (rose_n && fell_n && !bidx_q[0])
                held_q <= max_n;
            else
                held_q <= '0;
        end
    end

    // choose the value that represents the closing bucket
    logic [SAMPLE_W-1:0] out_v;
    always_comb begin
        case (mode_q)
            tbd_pkg::TBD_MODE_SAMPLE: out_v = mid_n;
            tbd_pkg::TBD_MODE_POSPK:  out_v = max_n;
            tbd_pkg::TBD_MODE_NEGPK:  out_v = min_n;
            tbd_pkg::TBD_MODE_NORMAL: begin
                if (rose_n && fell_n) begin
                    if (!bidx_q[0])
                        out_v = min_n;
                    else
                        out_v = max_of(max_n, held_q);
                end else begin
                    out_v = max_n;
                end
            end
            default: out_v = max_n;
        endcase
    end

    // registered point output toward trace memory
    always_ff @(posedge clk) begin
        if (rst) begin
            pt_valid   <= 1'b0;
            pt_index   <= '0;
            pt_value   <= '0;
            sweep_done <= 1'b0;
            last_q     <= '0;
        end else begin
            pt_valid   <= sweeping && bucket_end;
            sweep_done <= sweeping && bucket_end && bidx_q >= points_q;
            if (sweeping && bucket_end) begin
                pt_index     <= bidx_q;
                pt_value     <= out_v;
                last_q.valid <= 1'b1;
                last_q.index <= bidx_q;
                last_q.value <= out_v;
            end
        end
    end
endmodule
`default_nettype wire

// >>> tbd_detector_props.sv
// port assertions for the trace bucket detector
`timescale 1ns/1ps
`default_nettype none
module tbd_detector_props #(
    parameter int SAMPLE_W = 16,
    parameter int POINTS_W = 16
) (
    input  wire logic                clk,
    input  wire logic                rst,
    input  wire logic [31:0]         wb_adr_i,
    input  wire logic                wb_stb_i,
    input  wire logic                wb_cyc_i,
    input  wire logic                wb_ack_o,
    input  wire logic                wb_err_o,
    input  wire logic                smp_valid,
    input  wire logic                pt_valid,
    input  wire logic [POINTS_W-1:0] pt_index,
    input  wire logic                sweep_done
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);

    logic                req;
    logic                first_q;
    logic [POINTS_W-1:0] last_q;

    // a request is only new while no answer is out
    assign req = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;

    // first point of a sweep is pending after reset or a finished sweep
    always_ff @(posedge clk) begin
        if (rst || sweep_done)
            first_q <= 1'b1;
        else if (pt_valid)
            first_q <= 1'b0;
    end

    // previous index, used only once a point has been seen
    always_ff @(posedge clk) begin
        if (pt_valid)
            last_q <= pt_index;
    end

    a_ack_delay: assert property (req |=> wb_ack_o || wb_err_o)
        else $error("bus request not answered after one cycle");
    a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    a_ack_cause: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
        else $error("ack without request");
    a_err_unmapped: assert property (req && wb_adr_i > 32'h0000_001C
        |=> wb_err_o && !wb_ack_o)
        else $error("unmapped address not refused");
    a_pt_cause: assert property (pt_valid |-> $past(smp_valid))
        else $error("point without closing sample");
    a_done_last: assert property (sweep_done |-> pt_valid)
        else $error("sweep end without point");
    a_first_index: assert property (pt_valid && first_q
        |-> pt_index == 16'h0001)
        else $error("first bucket index not one");
    a_index_step: assert property (pt_valid && !first_q
        |-> pt_index == POINTS_W'(last_q + 1'b1))
        else $error("bucket index skipped");
    a_index_hold: assert property (!pt_valid && !$past(rst)
        |-> $stable(pt_index))
        else $error("index changed between points");
endmodule

bind tbd_detector tbd_detector_props #(
    .SAMPLE_W(SAMPLE_W),
    .POINTS_W(POINTS_W)
) u_props (
    .clk(clk), .rst(rst), .wb_adr_i(wb_adr_i), .wb_stb_i(wb_stb_i),
    .wb_cyc_i(wb_cyc_i), .wb_ack_o(wb_ack_o), .wb_err_o(wb_err_o),
    .smp_valid(smp_valid), .pt_valid(pt_valid), .pt_index(pt_index),
    .sweep_done(sweep_done)
);
`default_nettype wire

// >>> tbd_div.sv
// sequential unsigned divider, one quotient bit per clock
`timescale 1ns/1ps
`default_nettype none
module tbd_div #(
    parameter int W = 32
) (
    input  wire logic         clk,
    input  wire logic         rst,
    input  wire logic         start,
    input  wire logic [W-1:0] dividend,
    input  wire logic [W-1:0] divisor,
    output logic              busy,
    output logic              done,
    output logic [W-1:0]      quotient
);
    logic [W-1:0]         rem_q;
    logic [W-1:0]         quo_q;
    logic [W-1:0]         dvs_q;
    logic [$clog2(W):0]   cnt_q;
    logic [W:0]           trial;

    // refused at elaboration: the shift needs at least two bits
    if (W < 2) begin : g_width_chk
        $error("tbd_div: W too small");
    end

    assign trial    = {rem_q, quo_q[W-1]} - {1'b0, dvs_q};
    assign quotient = quo_q;

    // restoring division; divide by zero yields all ones
    always_ff @(posedge clk) begin
        done <= 1'b0;
        if (rst) begin
            busy  <= 1'b0;
            rem_q <= '0;
            quo_q <= '0;
            dvs_q <= '0;
            cnt_q <= '0;
        end else if (start && !busy) begin
            busy  <= 1'b1;
            rem_q <= '0;
            quo_q <= dividend;
            dvs_q <= divisor;
            cnt_q <= ($clog2(W)+1)'(W);
        end else if (busy) begin
            if (!trial[W]) begin
                rem_q <= trial[W-1:0];
                quo_q <= {quo_q[W-2:0], 1'b1};
            end else begin
                rem_q <= {rem_q[W-2:0], quo_q[W-1]};
                quo_q <= {quo_q[W-2:0], 1'b0};
            end
            cnt_q <= cnt_q - 1'b1;
            if (cnt_q == 1) begin
                busy <= 1'b0;
                done <= 1'b1;
            end
        end
    end
endmodule
`default_nettype wire

// >>> tbd_pkg.sv
// shared constants and types for the trace bucket detector
package tbd_pkg;
    localparam int SAMPLE_W = 16;
    localparam int POINTS_W = 16;
    localparam int COUNT_W  = 32;
    localparam int MAX_POINTS = 40001;
    localparam logic [POINTS_W-1:0] MIN_POINTS = 16'h0001;

    // wishbone register byte offsets
    localparam logic [7:0] ADDR_CTRL   = 8'h00;
    localparam logic [7:0] ADDR_POINTS = 8'h04;
    localparam logic [7:0] ADDR_SPAN   = 8'h08;
    localparam logic [7:0] ADDR_SWEEP  = 8'h0C;
    localparam logic [7:0] ADDR_BWIDTH = 8'h10;
    localparam logic [7:0] ADDR_BTIME  = 8'h14;
    localparam logic [7:0] ADDR_STATUS = 8'h18;
    localparam logic [7:0] ADDR_LAST   = 8'h1C;

    // control and status field positions
    localparam int CTRL_MODE_LSB = 0;
    localparam int CTRL_START    = 4;
    localparam int STAT_BUSY     = 0;
    localparam int STAT_DIV_BUSY = 1;

    // reset values
    localparam logic [POINTS_W-1:0] POINTS_RST = 16'h03E9;
    localparam logic [COUNT_W-1:0]  SWEEP_RST  = 32'h0000_2710;
    localparam logic [COUNT_W-1:0]  SPAN_RST   = 32'h05F5_E100;

    typedef enum logic [1:0] {
        TBD_MODE_SAMPLE = 2'h0,
        TBD_MODE_POSPK  = 2'h1,
        TBD_MODE_NEGPK  = 2'h2,
        TBD_MODE_NORMAL = 2'h3
    } tbd_mode_e;

    localparam tbd_mode_e MODE_RST = TBD_MODE_POSPK;

    typedef enum logic [1:0] {
        TBD_ST_IDLE  = 2'b00,
        TBD_ST_DIV   = 2'b01,
        TBD_ST_SWEEP = 2'b11
    } tbd_state_e;

    typedef struct packed {
        logic                valid;
        logic [POINTS_W-1:0] index;
        logic [SAMPLE_W-1:0] value;
    } tbd_point_s;
endpackage

// >>> tbd_trace_model.sv
// envelope sample source and trace memory model for the detector bench
`timescale 1ns/1ps
`default_nettype none
module tbd_trace_model (
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic        go,
    input  wire logic        slow,
    output logic             smp_valid,
    output logic      [15:0] smp_data,
    input  wire logic        pt_valid,
    input  wire logic [15:0] pt_index,
    input  wire logic [15:0] pt_value
);
    // four buckets of six: rising, noisy, noisy, falling
    logic [15:0] tab [0:23] = '{
        16'h0A, 16'h14, 16'h1E, 16'h28, 16'h32, 16'h3C,
        16'h05, 16'h5A, 16'h03, 16'h07, 16'h08, 16'h06,
        16'h0A, 16'h28, 16'h14, 16'h1E, 16'h19, 16'h0F,
        16'h46, 16'h3C, 16'h32, 16'h28, 16'h1E, 16'h14};
    logic [15:0] mem [0:7];
    int          n;
    logic        ph;

    // quiet outputs from time zero
    initial begin
        smp_valid = 1'b0;
        smp_data  = 16'h0000;
        n         = 0;
        ph        = 1'b0;
    end

    // idle data toggles so a stale value never passes for a sample
    always @(posedge clk) begin
        ph <= ~ph;
        if (!rst && go && n < 24 && (!slow || ph)) begin
            smp_valid <= 1'b1;
            smp_data  <= tab[n];
            n         <= n + 1;
        end else begin
            smp_valid <= 1'b0;
            smp_data  <= ~smp_data;
            if (!go)
                n <= 0;
        end
    end

    // trace memory, written on every point
    always @(posedge clk) begin
        if (pt_valid === 1'b1)
            mem[pt_index[2:0]] <= pt_value;
    end
endmodule
`default_nettype wire

// >>> trace_bucket_detector_bench.sv
// self-checking bench for the trace bucket detector
`timescale 1ns/1ps
`default_nettype none
module trace_bucket_detector_bench;
    logic        clk, rst, we, cyc, stb, go, slow, rerr;
    logic [31:0] adr, dat, rdat, dat_o;
    logic        ack, err, sv, pv, done;
    logic [15:0] sd, pi, pval;
    int          num_errors, n_tests, cyc_cnt, m;
    // expected point per mode: sample, positive, negative, normal
    logic [15:0] exp_v [0:3][0:3] = '{
        '{16'h28, 16'h07, 16'h1E, 16'h28}, '{16'h3C, 16'h5A, 16'h28, 16'h46},
        '{16'h0A, 16'h03, 16'h0A, 16'h14}, '{16'h3C, 16'h03, 16'h5A, 16'h46}};

    tbd_detector dut (
        .clk(clk), .rst(rst), .wb_adr_i(adr), .wb_dat_i(dat),
        .wb_dat_o(dat_o), .wb_we_i(we), .wb_sel_i(4'hF), .wb_stb_i(stb),
        .wb_cyc_i(cyc), .wb_ack_o(ack), .wb_err_o(err), .smp_valid(sv),
        .smp_data(sd), .pt_valid(pv), .pt_index(pi), .pt_value(pval),
        .sweep_done(done));
    tbd_trace_model mdl (
        .clk(clk), .rst(rst), .go(go), .slow(slow), .smp_valid(sv),
        .smp_data(sd), .pt_valid(pv), .pt_index(pi), .pt_value(pval));

    // 25 MHz clock
    always #20 clk = ~clk;

    task automatic stop_test();
        $display("checks %0d mismatches %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    // run is under a thousand cycles; this ceiling only cuts a hang
    always @(posedge clk) begin
        cyc_cnt++;
        if (cyc_cnt == 30000) begin
            num_errors++;
            stop_test();
        end
    end

    task automatic check(input string nm, input logic [31:0] got, exp);
        n_tests++;
        if (got !== exp) begin
            num_errors++;
            $display("CHECK FAILED %s exp %h got %h", nm, exp, got);
        end
    endtask

    // one classic cycle, held until ack or err is sampled
    task automatic bus(input logic [7:0] a, input logic w,
                       input logic [31:0] d);
        @(posedge clk);
        adr <= {24'h000000, a};
        we  <= w;
        dat <= d;
        cyc <= 1'b1;
        stb <= 1'b1;
        // no assumed latency; only the run ceiling ends a hang
        do
            @(posedge clk);
        while (ack !== 1'b1 && err !== 1'b1);
        rdat = dat_o;
        rerr = err;
        cyc <= 1'b0;
        stb <= 1'b0;
        we  <= 1'b0;
    endtask

    task automatic rd_chk(input string nm, input logic [7:0] a,
                          input logic [31:0] exp);
        bus(a, 1'b0, 32'h0);
        check(nm, rdat, exp);
    endtask

    task automatic t_regs();
        bus(tbd_pkg::ADDR_CTRL, 1'b0, 32'h0);
        check("mode", {30'h0, rdat[1:0]}, 32'h1);
        rd_chk("points", tbd_pkg::ADDR_POINTS, 32'h3E9);
        bus(tbd_pkg::ADDR_POINTS, 1'b1, 32'h0);
        rd_chk("pts_min", tbd_pkg::ADDR_POINTS, 32'h1);
        bus(tbd_pkg::ADDR_POINTS, 1'b1, 32'hFFFF);
        rd_chk("pts_max", tbd_pkg::ADDR_POINTS, 32'h9C41);
        bus(8'h20, 1'b0, 32'h0);
        check("unmapped", {31'h0, rerr}, 32'h1);
        bus(8'h02, 1'b1, 32'h0);
        check("unaligned", {31'h0, rerr}, 32'h1);
        $display("register test done");
    endtask

    // four buckets of six samples; slow source stalls every other cycle
    task automatic t_sweep(input int md, input logic sl);
        int i;
        bus(tbd_pkg::ADDR_POINTS, 1'b1, 32'h4);
        bus(tbd_pkg::ADDR_SPAN, 1'b1, 32'h12C);
        bus(tbd_pkg::ADDR_SWEEP, 1'b1, 32'h12);
        bus(tbd_pkg::ADDR_CTRL, 1'b1, 32'h10 | 32'(md));
        for (i = 0; i < 200; i++) begin
            bus(tbd_pkg::ADDR_STATUS, 1'b0, 32'h0);
            if (rdat[1:0] === 2'b01)
                break;
        end
        check("ready", {30'h0, rdat[1:0]}, 32'h1);
        rd_chk("bwidth", tbd_pkg::ADDR_BWIDTH, 32'h64);
        rd_chk("btime", tbd_pkg::ADDR_BTIME, 32'h6);
        go   <= 1'b1;
        slow <= sl;
        for (i = 0; i < 400; i++) begin
            @(posedge clk);
            if (done === 1'b1)
                break;
        end
        check("done", {31'h0, done}, 32'h1);
        @(posedge clk);
        go <= 1'b0;
        for (i = 1; i <= 4; i++) begin
            check("point", {16'h0, mdl.mem[i]}, {16'h0, exp_v[md][i-1]});
        end
        rd_chk("last", tbd_pkg::ADDR_LAST, {16'h4, exp_v[md][3]});
        $display("sweep test mode %0d done", md);
    endtask

    // reset for 20 cycles, then the scenarios
    initial begin
        clk = 1'b0;
        rst = 1'b1;
        {we, cyc, stb, go, slow} = 5'h00;
        adr = 32'h0;
        dat = 32'h0;
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        t_regs();
        for (m = 0; m < 4; m++)
            t_sweep(m, m[0]);
        t_sweep(3, 1'b0);
        stop_test();
    end
endmodule
`default_nettype wire
